// file: sim/asr_sram_model.sv
// Behavioural model of the 32-bit asynchronous static memory.
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model (
  // Clock used to sample the write overlap and to register the last bus level.
  input wire logic clock,
  // Memory pins.
  input wire logic [2:0] sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [3:0] lane_n,
  input wire logic [18:0] addr,
  input wire logic [31:0] dq,
  output logic [31:0] dq_drv,
  output logic [31:0] dq_en
);
  // Sparse word store; unwritten words read as zero.
  logic [31:0] mem [logic [18:0]];
  logic [31:0] last_q = 32'h0;
  logic [31:0] word;
  logic [31:0] wr_word;
  logic sel;
  // Composite select is active only with all three selects low.
  assign sel = (sel_n == 3'h0);
  // Read drive on enabled lanes only; a floated line shows the inverse of its last level.
  always_comb begin
    word = mem.exists(addr) ? mem[addr] : 32'h0;
    for (int i = 0; i < 4; i++) begin
      dq_en[i*8 +: 8] = {8{sel && !oe_n && we_n && !lane_n[i]}};
    end
    dq_drv = (dq_en & word) | (~dq_en & ~last_q);
  end
  // Store enabled lanes while selects and strobe overlap low.
  always @(posedge clock) begin
    last_q <= dq_drv;
    if (sel && !we_n) begin
      wr_word = mem.exists(addr) ? mem[addr] : 32'h0;
      for (int i = 0; i < 4; i++) begin
        if (!lane_n[i]) wr_word[i*8 +: 8] = dq[i*8 +: 8];
      end
      mem[addr] = wr_word;
    end
  end
endmodule // asr_sram_model
`default_nettype wire

// file: sim/async_sram_access_protocol_tb.sv
// Self-checking testbench for the static memory controller.
`timescale 1ns/100ps
`default_nettype none
module async_sram_access_protocol_tb;
  localparam int PU = 4;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
  logic [18:0] req_addr = 19'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_lane = 4'h0;
  logic req_ready, rsp_valid, retain_ok, mem_oe_n, mem_we_n;
  logic [2:0] mem_sel_n;
  logic [3:0] mem_lane_n;
  logic [18:0] mem_addr;
  logic [31:0] rsp_rdata, mem_dq_out, mem_dq_oe, mem_dq_in, drv, en, rd;
  int num_errors = 0;
  int check_count = 0;
  // Shared data bus: controller bits win where enabled, the memory elsewhere.
  assign mem_dq_in = (mem_dq_oe & mem_dq_out) | (~mem_dq_oe & drv);
  asr_ctrl #(.POWER_UP_CYC(PU)) u_asr_ctrl (.clock, .rst, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_lane, .req_ready, .rsp_valid, .rsp_rdata, .retain_req, .retain_ok,
    .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_lane_n, .mem_addr, .mem_dq_out, .mem_dq_oe,
    .mem_dq_in);
  asr_sram_model u_asr_sram_model (.clock(clock), .sel_n(mem_sel_n), .oe_n(mem_oe_n),
    .we_n(mem_we_n), .lane_n(mem_lane_n), .addr(mem_addr), .dq(mem_dq_in), .dq_drv(drv),
    .dq_en(en));
  // Clock of 50 ns period.
  initial begin
    forever #25 clock = ~clock;
  end
  // Compares one value and counts the check.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request, held until taken, with the pin phases watched afterwards.
  task automatic access(input logic wr, input logic [18:0] a, input logic [31:0] d,
      input logic [3:0] ln);
    int n;
    int p;
    logic saw;
    logic [3:0] lane_exp;
    saw = 1'b0;
    lane_exp = ~ln;
    p = 0;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_lane <= ln;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    repeat (6) begin
      @(posedge clock);
      if (mem_sel_n === 3'h0) begin
        chk(mem_addr, a);
        chk(mem_lane_n, lane_exp);
        chk(mem_oe_n, wr);
        if (!wr) chk(mem_we_n, 1'b1);
      end
      if (mem_we_n === 1'b0) begin
        saw = 1'b1;
        chk(mem_sel_n, 3'h0);
        chk(mem_dq_oe, 32'hffffffff);
        chk(mem_dq_out, d);
        chk(en, 32'h0);
      end
      if (rsp_valid === 1'b1) begin
        p++;
        rd = rsp_rdata;
      end
    end
    chk(saw, wr);
    chk(p, !wr);
  endtask
  // Ready must wait out the power-up delay after reset.
  task automatic t_power();
    int n;
    n = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    chk(n >= PU && n <= PU + 2, 1);
    chk(mem_sel_n, 3'h7);
  endtask
  // Full word written to the top address and read back.
  task automatic t_full();
    access(1'b1, 19'h7ffff, 32'h12345678, 4'hf);
    access(1'b0, 19'h7ffff, 32'h0, 4'hf);
    chk(rd, 32'h12345678);
  endtask
  // Each lane alone: written lane changes, others kept; a one-lane read is checked on that lane only.
  task automatic t_lanes();
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 32'hff << (8 * i);
      access(1'b1, 19'h10, 32'h0, 4'hf);
      access(1'b1, 19'h10, 32'hffffffff, 4'h1 << i);
      access(1'b0, 19'h10, 32'h0, 4'hf);
      chk(rd, m);
      access(1'b0, 19'h10, 32'h0, 4'h1 << i);
      chk(rd & m, m);
    end
  endtask
  // Retention hold: deselected, and a pending write is not taken.
  task automatic t_retain();
    retain_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk(retain_ok, 1'b1);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= 19'h7ffff;
    req_wdata <= 32'hdeadbeef;
    req_lane <= 4'hf;
    repeat (5) begin
      @(posedge clock);
      chk(mem_sel_n, 3'h7);
    end
    req_valid <= 1'b0;
    retain_req <= 1'b0;
    @(posedge clock);
    access(1'b0, 19'h7ffff, 32'h0, 4'hf);
    chk(rd, 32'h12345678);
  endtask
  // Main sequence.
  initial begin
    t_power();
    t_full();
    t_lanes();
    t_retain();
    stop_test();
  end
  // Watchdog cuts a hang short.
  initial begin
    #50000;
    num_errors++;
    stop_test();
  end
endmodule // async_sram_access_protocol_tb
`default_nettype wire

// file: verilog/asr_counter.sv
// Down counter that times the power-up, write and read phases of the controller.
`timescale 1ns/100ps
`default_nettype none
module asr_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Load and status.
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);
  // Holds the remaining cycle count.
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } asr_cnt_s;
  asr_cnt_s s_q;
  asr_cnt_s s_d;

  // Loads on request, otherwise counts down to zero.
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = value;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // Registers the count.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Done is high while the count is at zero and no load is pending.
  assign done = (s_q.cnt == '0) && !load;
endmodule // asr_counter
`default_nettype wire

// file: verilog/asr_ctrl.sv
// Host-side controller that drives an asynchronous 32-bit static memory.
`timescale 1ns/100ps
`default_nettype none
`include "asr_defines.svh"
// Operation
// - Select active only when all three low.
// - Assert all selects and strobe to write.
// - Data set-up and hold around ending edge.
// - Strobe-ended write covers float plus set-up.
// - Address valid before selects go low (here driven on the same edge as the selects).
// - Strobe stays high through every read.
// - Deselect before retention, zero delay.
// - Wait power-up delay before first access.
module asr_ctrl
  import asr_pkg::*;
#(
  parameter int POWER_UP_CYC = `ASR_POWER_UP_CYC,
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // User request side.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [18:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_lane,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // Retention request and status.
  input wire logic retain_req,
  output logic retain_ok,
  // Memory pins.
  output logic [2:0] mem_sel_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [3:0] mem_lane_n,
  output logic [18:0] mem_addr,
  output logic [31:0] mem_dq_out,
  output logic [31:0] mem_dq_oe,
  input wire logic [31:0] mem_dq_in
);
  // Derived phase lengths in cycles.
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(`ASR_WRITE_CYC);
  localparam logic [CNT_W-1:0] READ_CYC = CNT_W'(`ASR_READ_CYC);
  localparam logic [CNT_W-1:0] PUP_CYC = CNT_W'(POWER_UP_CYC);

  // Sequencer state, pins and registered outputs in one struct.
  typedef struct packed {
    asr_state_e st;
    asr_pins_s pins;
    logic ready;
    logic rsp;
    logic [31:0] rdata;
    logic retain;
  } asr_ctl_s;
  asr_ctl_s s_q;
  asr_ctl_s s_d;
  logic cnt_load; // Starts a timed phase.
  logic [CNT_W-1:0] cnt_value; // Length of that phase, less one.
  logic cnt_done; // Phase finished.
  logic pup_armed_q; // Power-up count has been loaded.

  // Phase timer.
  asr_counter #(.WIDTH(CNT_W)) u_cnt (
    .clock(clock),
    .rst(rst),
    .load(cnt_load),
    .value(cnt_value),
    .done(cnt_done)
  );

  // Next-state logic for the access sequencer.
  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    cnt_load = 1'b0;
    cnt_value = '0;
    unique case (s_q.st)
      ASR_POWER_UP: begin
        // Hold off every access until the supply has settled.
        if (!pup_armed_q) begin
          // The first cycle out of reset arms the power-up wait.
          cnt_load = 1'b1;
          cnt_value = PUP_CYC - 1'b1;
        end else if (cnt_done) begin
          s_d.st = ASR_IDLE;
          s_d.ready = 1'b1;
          s_d.retain = 1'b1;
        end
      end
      ASR_IDLE: begin
        // Idle means fully deselected, so retention is safe at once.
        s_d.retain = !req_valid;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.retain = 1'b0;
          // Address and lanes go out with the selects, never after.
          s_d.pins.addr = req_addr;
          s_d.pins.lane_n = ~req_lane;
          s_d.pins.sel_n = 3'b000;
          cnt_load = 1'b1;
          if (req_write) begin
            // All selects and the strobe low together start the write.
            s_d.pins.we_n = 1'b0;
            s_d.pins.oe_n = 1'b1;
            s_d.pins.dq_out = req_wdata;
            s_d.pins.dq_oe = '1;
            cnt_value = WRITE_CYC - 1'b1;
            s_d.st = ASR_WRITE;
          end else begin
            // Strobe stays high for the whole read.
            s_d.pins.we_n = 1'b1;
            s_d.pins.oe_n = 1'b0;
            cnt_value = READ_CYC - 1'b1;
            s_d.st = ASR_READ;
          end
        end
      end
      ASR_WRITE: begin
        // Strobe rises first; data stays on the bus past that edge.
        if (cnt_done) begin
          s_d.pins.we_n = 1'b1;
          s_d.st = ASR_WRITE_END;
        end
      end
      ASR_WRITE_END: begin
        // Deselect and release data one cycle after the ending edge.
        s_d.pins.sel_n = 3'b111;
        s_d.pins.dq_oe = '0;
        s_d.pins.lane_n = 4'hf;
        s_d.ready = 1'b1;
        s_d.st = ASR_IDLE;
      end
      ASR_READ: begin
        // Hold the read for the cycle time, then sample.
        if (cnt_done) begin
          s_d.st = ASR_READ_DONE;
        end
      end
      ASR_READ_DONE: begin
        // Capture data and end the read by deselecting.
        s_d.rdata = mem_dq_in;
        s_d.rsp = 1'b1;
        s_d.pins.sel_n = 3'b111;
        s_d.pins.oe_n = 1'b1;
        s_d.pins.lane_n = 4'hf;
        s_d.ready = 1'b1;
        s_d.st = ASR_IDLE;
      end
    endcase
    // A retention request only blocks new accesses.
    if (retain_req && s_q.st == ASR_IDLE) begin
      s_d.ready = 1'b0;
    end else if (s_d.st == ASR_IDLE && s_q.st != ASR_POWER_UP) begin
      s_d.ready = 1'b1;
    end
  end

  // Registers the state; reset returns to ASR_POWER_UP with all pins inactive.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ASR_POWER_UP;
      s_q.pins.sel_n <= 3'b111;
      s_q.pins.oe_n <= 1'b1;
      s_q.pins.we_n <= 1'b1;
      s_q.pins.lane_n <= 4'hf;
    end else begin
      s_q <= s_d;
    end
  end

  // Reload helper so the power-up wait restarts on every reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      pup_armed_q <= 1'b0;
    end else begin
      pup_armed_q <= 1'b1;
    end
  end

  // Outputs straight from flip-flops.
  assign mem_sel_n = s_q.pins.sel_n;
  assign mem_oe_n = s_q.pins.oe_n;
  assign mem_we_n = s_q.pins.we_n;
  assign mem_lane_n = s_q.pins.lane_n;
  assign mem_addr = s_q.pins.addr;
  assign mem_dq_out = s_q.pins.dq_out;
  assign mem_dq_oe = s_q.pins.dq_oe;
  assign req_ready = s_q.ready;
  assign rsp_valid = s_q.rsp;
  assign rsp_rdata = s_q.rdata;
  assign retain_ok = s_q.retain;

  // Power-up count since reset, for checking.
  logic [31:0] since_rst_q; // Cycles since reset release.
  always_ff @(posedge clock) begin
    if (rst) begin
      since_rst_q <= '0;
    end else if (since_rst_q != 32'hffffffff) begin
      since_rst_q <= since_rst_q + 32'h1;
    end
  end

  // Strobe-low length so far, for checking the write pulse.
  logic [CNT_W-1:0] we_low_q; // Cycles the strobe has been low.
  always_ff @(posedge clock) begin
    if (rst) begin
      we_low_q <= '0;
    end else if (mem_we_n) begin
      we_low_q <= '0;
    end else begin
      we_low_q <= we_low_q + 1'b1;
    end
  end

  // No select may fall before the power-up delay.
  power_up_wait_a: assert property (@(posedge clock) disable iff (rst)
    (mem_sel_n != 3'b111) |-> (since_rst_q >= 32'(POWER_UP_CYC)))
    else $error("access before power-up delay");
  // Selects always move together.
  sel_together_a: assert property (@(posedge clock) disable iff (rst)
    (mem_sel_n == 3'b000) || (mem_sel_n == 3'b111))
    else $error("chip selects split");
  // Strobe low only with all selects low.
  write_start_a: assert property (@(posedge clock) disable iff (rst)
    !mem_we_n |-> (mem_sel_n == 3'b000) && mem_oe_n)
    else $error("strobe low without selects");
  // Strobe stayed low for at least the full write length.
  write_len_a: assert property (@(posedge clock) disable iff (rst)
    $rose(mem_we_n) |-> (we_low_q >= WRITE_CYC))
    else $error("write strobe too short");
  // Data and selects hold one cycle past the strobe rising.
  data_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(mem_we_n) |-> (mem_dq_oe == '1) && (mem_sel_n == 3'b000))
    else $error("data released at write end");
  // Address stays still while selected.
  addr_stable_a: assert property (@(posedge clock) disable iff (rst)
    (mem_sel_n == 3'b000) && $past(mem_sel_n == 3'b000) |-> $stable(mem_addr))
    else $error("address moved while selected");
  // Strobe high throughout a read.
  read_strobe_a: assert property (@(posedge clock) disable iff (rst)
    !mem_oe_n |-> mem_we_n && (mem_dq_oe == '0))
    else $error("strobe low during read");
  // Retention only while deselected.
  retain_desel_a: assert property (@(posedge clock) disable iff (rst)
    retain_ok |-> (mem_sel_n == 3'b111) && mem_we_n)
    else $error("retention while selected");
  // A read answers within four cycles of the output enable falling.
  read_answer_a: assert property (@(posedge clock) disable iff (rst)
    $fell(mem_oe_n) |-> ##[1:4] rsp_valid)
    else $error("read answer late");
endmodule // asr_ctrl
`default_nettype wire

// file: verilog/asr_defines.svh
// Timing constants for the asynchronous static memory controller.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
// Clock period in picoseconds (20 MHz).
`define ASR_CLK_PS 50000
// Power-up delay before the first access, in microseconds.
`define ASR_POWER_UP_US 100
// Power-up delay in clock cycles, rounded up.
`define ASR_POWER_UP_CYC ((`ASR_POWER_UP_US * 1000000 + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
// Strobe-low to data float delay, picoseconds.
`define ASR_STROBE_TO_FLOAT_PS 5000
// Data set-up to write end, picoseconds.
`define ASR_DATA_SETUP_PS 5500
// Least write pulse width, picoseconds.
`define ASR_WRITE_PULSE_PS 7000
// Least read cycle time, picoseconds.
`define ASR_READ_CYCLE_PS 10000
// Write strobe low time in cycles, rounded up, never below one.
`define ASR_WRITE_CYC (((`ASR_STROBE_TO_FLOAT_PS + `ASR_DATA_SETUP_PS > `ASR_WRITE_PULSE_PS ? `ASR_STROBE_TO_FLOAT_PS + `ASR_DATA_SETUP_PS : `ASR_WRITE_PULSE_PS) + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
// Read cycle length in cycles, rounded up; one more cycle is used to sample.
`define ASR_READ_CYC ((`ASR_READ_CYCLE_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
// Deselect to retention delay, nanoseconds.
`define ASR_DESELECT_TO_RETENTION_NS 0
`endif

// file: verilog/asr_pkg.sv
// Types for the asynchronous static memory controller.
`default_nettype none
package asr_pkg;
  // Controller sequencer states.
  typedef enum logic [2:0] {
    ASR_POWER_UP,
    ASR_IDLE,
    ASR_WRITE,
    ASR_WRITE_END,
    ASR_READ,
    ASR_READ_DONE
  } asr_state_e;
  // Memory-side pin group.
  typedef struct packed {
    logic [2:0] sel_n;
    logic oe_n;
    logic we_n;
    logic [3:0] lane_n;
    logic [18:0] addr;
    logic [31:0] dq_out;
    logic [31:0] dq_oe;
  } asr_pins_s;
endpackage : asr_pkg
`default_nettype wire
